/* inc/asr_pkg.sv */
// Purpose: Shared constants and types for the converter serial readout link.
// Assumes: One core clock on each end; the serial clock is a sampled input or a divided output.
// Notes: Conversion times are in core clock cycles of 40 ns.
`default_nettype none
package asr_pkg;
  // ==========================================================================
  // Widths and timing.
  // ==========================================================================
  localparam int ASR_DATA_W = 18;
  localparam int ASR_CNT_W = 12;
  localparam int ASR_CLK_NS = 40;
  localparam int ASR_TCONV_MIN_NS = 400;
  localparam int ASR_TCONV_MAX_NS = 500;
  localparam int ASR_TCONV_MIN_CYC = (ASR_TCONV_MIN_NS + ASR_CLK_NS - 1) / ASR_CLK_NS;
  localparam int ASR_TCONV_MAX_CYC = ASR_TCONV_MAX_NS / ASR_CLK_NS;
  localparam int ASR_SCK_HALF_CYC = 4;
  localparam int ASR_DONE_BIT = 19;
  localparam logic [17:0] ASR_RESULT_RST = 18'h00000;

  // Mode latched at the start of a conversion.
  typedef enum logic [1:0] {
    ASR_MODE_SEL = 2'b00,
    ASR_MODE_CHAIN = 2'b01,
    ASR_MODE_CHAIN_BUSY = 2'b10
  } asr_mode_t;
endpackage : asr_pkg
`default_nettype wire

/* inc/asr_link_if.sv */
// Purpose: Pin-level link between the host and the converter.
// Assumes: Serial output is a tri-state pin with a pull-up in the bench.
// Notes: Wire level is resolved here from the enable.
`timescale 1ns/1ps
`default_nettype none
interface asr_link_if;
  logic convert_strobe;
  logic select_chain_in;
  logic sck;
  logic serial_out_o;
  logic serial_out_oe;
  wire serial_out;

  // Pull-up on the serial output line.
  assign serial_out = serial_out_oe ? serial_out_o : 1'b1;

  modport dev (
    input convert_strobe, select_chain_in, sck,
    output serial_out_o, serial_out_oe
  );
  modport host (
    output convert_strobe, select_chain_in, sck,
    input serial_out
  );
endinterface : asr_link_if
`default_nettype wire

/* hw/asr_dev.sv */
// Purpose: Converter end: conversion timing, mode choice and serial shift-out.
// Assumes: Link pins come from outside the domain and are synchronised here.
// Notes: Conversion time is a parameter; the result comes from the user port.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - select high at strobe rise: select mode, tristate
// - host holds strobe through conversion and readback
// - select and strobe low drive output low
// - host returns select low for busy indication
// - conversion end in busy mode drives output
// - result shifts out MSB first on falling edges
// - bit stays valid across both clock edges
// - tristate at 19th falling edge or select rise
// - clock low at rise: chain, busy disabled
// - host holds strobe through chain readback
// - chain without busy presents MSB at end
// - chain input shifts into result register
// - host gives eighteen clocks per converter
// - clock high at rise: chain, busy enabled
// - chain busy end drives output high
// - host gives eighteen N plus one clocks
// - host allows lower rate in chain mode; host uses the same ASR_SCK_HALF_CYC half period in every mode
// - select level at strobe rise picks mode
// - conversion finishes whatever the strobe does
module asr_dev #(
  parameter int TCONV_CYC = asr_pkg::ASR_TCONV_MAX_CYC
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Link.
  asr_link_if.dev link,
  // User side.
  input wire logic [asr_pkg::ASR_DATA_W-1:0] sample_in,
  output logic conv_busy,
  output logic conv_done
);
  import asr_pkg::*;

  // ==========================================================================
  // Synchronisers.
  // ==========================================================================
  logic [1:0] cnv_s_r, sdi_s_r, sck_s_r;
  logic cnv_d_r, sdi_d_r, sck_d_r;
  logic cnv_rise, sdi_rise, sck_fall;

  // Two flops per pin; only the second stage feeds logic.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnv_s_r <= 2'h0;
      sdi_s_r <= 2'h3; // Select idles high, so reset leaves no false rise behind.
      sck_s_r <= 2'h0;
    end else begin
      cnv_s_r <= {cnv_s_r[0], link.convert_strobe};
      sdi_s_r <= {sdi_s_r[0], link.select_chain_in};
      sck_s_r <= {sck_s_r[0], link.sck};
    end
  end

  // Delayed copies for edge finding.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnv_d_r <= 1'b0;
      sdi_d_r <= 1'b1;
      sck_d_r <= 1'b0;
    end else begin
      cnv_d_r <= cnv_s_r[1];
      sdi_d_r <= sdi_s_r[1];
      sck_d_r <= sck_s_r[1];
    end
  end

  assign cnv_rise = cnv_s_r[1] & ~cnv_d_r;
  assign sdi_rise = sdi_s_r[1] & ~sdi_d_r;
  assign sck_fall = ~sck_s_r[1] & sck_d_r;

  // ==========================================================================
  // Conversion timer.
  // ==========================================================================
  logic conv_r;
  logic [ASR_CNT_W-1:0] tconv_r;
  logic conv_end;
  asr_mode_t mode_r;

  // Timer ignores the strobe once started, so a dropped strobe cannot cut it short.
  assign conv_end = conv_r && (tconv_r == ASR_CNT_W'(TCONV_CYC - 1));

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      conv_r <= 1'b0;
      tconv_r <= '0;
    end else if (cnv_rise && !conv_r) begin
      conv_r <= 1'b1;
      tconv_r <= '0;
    end else if (conv_end) begin
      conv_r <= 1'b0;
    end else if (conv_r) begin
      tconv_r <= tconv_r + ASR_CNT_W'(1);
    end
  end

  // Mode is taken from the select and clock levels at the strobe rise.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mode_r <= ASR_MODE_SEL;
    end else if (cnv_rise && !conv_r) begin
      if (sdi_s_r[1]) begin
        mode_r <= ASR_MODE_SEL;
      end else if (sck_s_r[1]) begin
        mode_r <= ASR_MODE_CHAIN_BUSY;
      end else begin
        mode_r <= ASR_MODE_CHAIN;
      end
    end
  end

  // ==========================================================================
  // Result shift register and output.
  // ==========================================================================
  logic [ASR_DATA_W-1:0] shreg_r;
  logic [4:0] falls_r;
  logic rd_r;
  logic busy_lead_r;
  logic oe_r, out_r;

  // Readback window: opens at conversion end; closes at bit 19 or select rise in select mode, at strobe fall in chain modes.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rd_r <= 1'b0;
      falls_r <= 5'h00;
    end else if (conv_end) begin
      rd_r <= 1'b1;
      falls_r <= 5'h00;
    end else if (rd_r && mode_r == ASR_MODE_SEL &&
                 (sdi_rise || (sck_fall && falls_r == 5'(ASR_DONE_BIT - 1)))) begin
      rd_r <= 1'b0;
    end else if (!cnv_s_r[1] && mode_r != ASR_MODE_SEL) begin
      rd_r <= 1'b0;
    end else if (rd_r && sck_fall) begin
      falls_r <= falls_r + 5'h01;
    end
  end

  // Busy lead bit in front of data for select-busy and chain-busy modes.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      busy_lead_r <= 1'b0;
    end else if (conv_end) begin
      busy_lead_r <= (mode_r != ASR_MODE_CHAIN);
    end else if (sck_fall) begin
      busy_lead_r <= 1'b0;
    end
  end

  // Load at end, then shift on each falling edge after any busy lead bit; chain feeds the select input in.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      shreg_r <= ASR_RESULT_RST;
    end else if (conv_end) begin
      shreg_r <= sample_in;
    end else if (rd_r && sck_fall && !busy_lead_r) begin
      if (mode_r == ASR_MODE_SEL) begin
        shreg_r <= {shreg_r[ASR_DATA_W-2:0], 1'b0};
      end else begin
        shreg_r <= {shreg_r[ASR_DATA_W-2:0], sdi_s_r[1]};
      end
    end
  end

  // Output pin drive; the bit changes only on falling edges so it holds across both.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      oe_r <= 1'b0;
      out_r <= 1'b0;
    end else if (cnv_rise && !conv_r) begin
      // The mode register changes on this same edge, so decide from the select level.
      oe_r <= !sdi_s_r[1];
      out_r <= 1'b0;
    end else if (!sdi_s_r[1] && !cnv_s_r[1]) begin
      oe_r <= 1'b1;
      out_r <= 1'b0;
    end else if (conv_r || !rd_r) begin
      oe_r <= (mode_r != ASR_MODE_SEL); // Chain drives low, so the busy rise is an edge.
      out_r <= 1'b0;
    end else if (mode_r == ASR_MODE_SEL && sdi_s_r[1]) begin
      oe_r <= 1'b0;
      out_r <= 1'b0;
    end else begin
      oe_r <= 1'b1;
      out_r <= busy_lead_r ? (mode_r == ASR_MODE_CHAIN_BUSY) : shreg_r[ASR_DATA_W-1];
    end
  end

  assign link.serial_out_o = out_r;
  assign link.serial_out_oe = oe_r;

  // Status outputs for the user side.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      conv_busy <= 1'b0;
      conv_done <= 1'b0;
    end else begin
      conv_busy <= conv_r;
      conv_done <= conv_end;
    end
  end
endmodule : asr_dev
`default_nettype wire

/* hw/asr_host.sv */
// Purpose: Host end: starts conversions, selects the mode, clocks data back.
// Assumes: Serial output has a pull-up; the host makes the serial clock.
// Notes: Every mode waits a fixed time beyond the longest conversion before clocking.
`timescale 1ns/1ps
`default_nettype none
module asr_host #(
  parameter int NCONV = 1,
  parameter int TWAIT_CYC = asr_pkg::ASR_TCONV_MAX_CYC + 4
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Link.
  asr_link_if.host link,
  // User side.
  input wire logic start,
  input wire asr_pkg::asr_mode_t mode_in,
  output logic [asr_pkg::ASR_DATA_W*NCONV-1:0] data_out,
  output logic data_valid,
  output logic idle
);
  import asr_pkg::*;

  typedef enum logic [2:0] {
    ASRH_IDLE = 3'b000,
    ASRH_ARM = 3'b001,
    ASRH_WAIT = 3'b010,
    ASRH_SHIFT = 3'b011,
    ASRH_END = 3'b100
  } asrh_state_t;

  localparam int NBITS = ASR_DATA_W * NCONV;

  asrh_state_t st_r;
  asr_mode_t md_r;
  logic [1:0] sdo_s_r;
  logic cnv_r, sdi_r, sck_r;
  logic [ASR_CNT_W-1:0] cnt_r;
  logic [ASR_CNT_W-1:0] bits_r;
  logic [NBITS-1:0] cap_r;

  // Serial output sampled through two flops.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sdo_s_r <= 2'h3;
    end else begin
      sdo_s_r <= {sdo_s_r[0], link.serial_out};
    end
  end

  // Sequencer; strobe stays high through conversion and readback.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_r <= ASRH_IDLE;
      md_r <= ASR_MODE_SEL;
      cnv_r <= 1'b0;
      sdi_r <= 1'b1;
      sck_r <= 1'b0;
      cnt_r <= '0;
      bits_r <= '0;
      cap_r <= '0;
      data_valid <= 1'b0;
    end else begin
      data_valid <= 1'b0;
      case (st_r)
        ASRH_IDLE: begin
          cnv_r <= 1'b0;
          if (start) begin
            md_r <= mode_in;
            sdi_r <= (mode_in == ASR_MODE_SEL);
            sck_r <= (mode_in == ASR_MODE_CHAIN_BUSY);
            cnt_r <= '0;
            st_r <= ASRH_ARM;
          end
        end
        ASRH_ARM: begin
          // Setup before the strobe edge, then raise it.
          cnt_r <= cnt_r + ASR_CNT_W'(1);
          if (cnt_r == ASR_CNT_W'(ASR_SCK_HALF_CYC)) begin
            cnv_r <= 1'b1;
            cnt_r <= '0;
            st_r <= ASRH_WAIT;
          end
        end
        ASRH_WAIT: begin
          cnt_r <= cnt_r + ASR_CNT_W'(1);
          if (cnt_r == ASR_CNT_W'(ASR_SCK_HALF_CYC)) begin
            sck_r <= 1'b0;
            if (md_r == ASR_MODE_SEL) begin
              sdi_r <= 1'b0;
            end
          end
          if (cnt_r >= ASR_CNT_W'(TWAIT_CYC)) begin
            cnt_r <= '0;
            bits_r <= '0;
            st_r <= ASRH_SHIFT;
          end
        end
        ASRH_SHIFT: begin
          // Capture on the falling edge of the divided clock.
          cnt_r <= cnt_r + ASR_CNT_W'(1);
          if (cnt_r == ASR_CNT_W'(ASR_SCK_HALF_CYC - 1)) begin
            sck_r <= 1'b1;
          end else if (cnt_r == ASR_CNT_W'(2 * ASR_SCK_HALF_CYC - 1)) begin
            sck_r <= 1'b0;
            cnt_r <= '0;
            bits_r <= bits_r + ASR_CNT_W'(1);
            if (!(md_r == ASR_MODE_CHAIN_BUSY && bits_r == '0) && md_r != ASR_MODE_SEL) begin
              cap_r <= {cap_r[NBITS-2:0], sdo_s_r[1]};
            end else if (md_r == ASR_MODE_SEL && bits_r != '0) begin
              cap_r <= {cap_r[NBITS-2:0], sdo_s_r[1]};
            end
            // Count includes the busy lead bit where the mode has one.
            if (bits_r == ASR_CNT_W'(NBITS + ((md_r == ASR_MODE_CHAIN) ? 0 : 1) - 1)) begin
              st_r <= ASRH_END;
            end
          end
        end
        ASRH_END: begin
          sdi_r <= 1'b1;
          cnv_r <= 1'b0;
          data_valid <= 1'b1;
          st_r <= ASRH_IDLE;
        end
        default: st_r <= ASRH_IDLE;
      endcase
    end
  end

  assign link.convert_strobe = cnv_r;
  assign link.select_chain_in = sdi_r;
  assign link.sck = sck_r;
  assign data_out = cap_r;

  // Idle flag from the state register and the start input.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      idle <= 1'b1;
    end else begin
      idle <= (st_r == ASRH_IDLE) && !start;
    end
  end
endmodule : asr_host
`default_nettype wire

/* sim/asr_chk_sva.sv */
// Purpose: Pin checker for the converter readout link.
// Assumes: Link pins are levels sampled on core_clk; serial output comes from the converter, the rest from the host.
// Notes: Windows allow for the two-flop sync inside the converter.
`timescale 1ns/1ps
`default_nettype none
module asr_chk (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Link pins.
  input wire logic convert_strobe,
  input wire logic select_chain_in,
  input wire logic sck,
  input wire logic serial_out_o,
  input wire logic serial_out_oe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic sel_r;
  logic sck_d_r;
  logic [3:0] fall_n_r;
  logic cnv_q_r;
  logic lead_wait_r;
  // ==========================================================================
  // Helpers.
  // ==========================================================================
  // Select mode flag, set while strobe and select are both high, cleared when the strobe falls.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sel_r <= 1'b0;
    end else if (convert_strobe && !sel_r && select_chain_in) begin
      sel_r <= 1'b1;
    end else if (!convert_strobe) begin
      sel_r <= 1'b0;
    end
  end
  // Cycles since the last sck fall; it saturates so idle time never wraps.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sck_d_r <= 1'b0;
      fall_n_r <= 4'hf;
    end else begin
      sck_d_r <= sck;
      fall_n_r <= (sck_d_r && !sck) ? 4'h0 : (fall_n_r == 4'hf ? fall_n_r : fall_n_r + 4'h1);
    end
  end
  // Chain busy start; its lead bit rises at conversion end, far from the last sck fall.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnv_q_r <= 1'b0;
      lead_wait_r <= 1'b0;
    end else begin
      cnv_q_r <= convert_strobe;
      if (convert_strobe && !cnv_q_r && !select_chain_in && sck) begin
        lead_wait_r <= 1'b1;
      end else if (!convert_strobe || (serial_out_oe && serial_out_o)) begin
        lead_wait_r <= 1'b0;
      end
    end
  end
  // ==========================================================================
  // Assertions.
  // ==========================================================================
  AST_SEL_HIZ: assert property ($rose(convert_strobe) && select_chain_in
    |-> ##5 (!serial_out_oe) [*6]) else $error("output driven in select conversion");
  AST_LOW_IDLE: assert property ((!convert_strobe && !select_chain_in) [*5]
    |-> serial_out_oe && !serial_out_o) else $error("idle output not driven low");
  AST_SEL_END: assert property ($rose(convert_strobe) && select_chain_in
    |-> ##[12:24] serial_out_oe) else $error("no drive at select conversion end");
  AST_HOLD: assert property ($rose(sck) && serial_out_oe
    |=> $stable(serial_out_o) [*4]) else $error("bit moved while clock high");
  AST_SHIFT: assert property (convert_strobe && serial_out_oe && $past(serial_out_oe)
    && $changed(serial_out_o) && fall_n_r != 4'hf && !lead_wait_r |-> fall_n_r inside {[1:7]})
    else $error("bit moved away from a clock fall");
  AST_SEL_REL: assert property (sel_r && convert_strobe && $rose(select_chain_in)
    |-> ##[1:6] !serial_out_oe) else $error("select rise left output driven");
  AST_CHAIN: assert property ($rose(convert_strobe) && !select_chain_in && !sck
    |-> serial_out_oe [*8]) else $error("chain output released");
  AST_BUSY: assert property ($rose(convert_strobe) && !select_chain_in && sck
    |-> ##[12:24] serial_out_oe && serial_out_o) else $error("no chain busy high");
  cover property ($rose(convert_strobe) && select_chain_in);
  cover property ($rose(convert_strobe) && !select_chain_in && !sck);
  cover property ($rose(convert_strobe) && !select_chain_in && sck);
endmodule // asr_chk
`default_nettype wire

/* sim/adc_serial_readout_chain_bench.sv */
// Purpose: Bench joining host and converter across the link.
// Assumes: Default conversion and wait lengths of both ends.
// Notes: Every mode runs with edge and back-to-back values.
`timescale 1ns/1ps
`default_nettype none
module adc_serial_readout_chain_bench;
  import asr_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic start = 1'b0;
  asr_mode_t mode_in = ASR_MODE_SEL;
  logic [ASR_DATA_W-1:0] sample_in = 18'h00000;
  logic [ASR_DATA_W-1:0] data_out;
  logic data_valid;
  logic idle;
  logic conv_busy;
  logic conv_done;
  int n_fail = 0;
  int n_compared = 0;
  asr_link_if link();
  // ==========================================================================
  // Clock, ends and checker.
  // ==========================================================================
  always #20 core_clk = ~core_clk;
  asr_host i_asr_host (.core_clk(core_clk), .rst(rst), .link(link), .start(start),
    .mode_in(mode_in), .data_out(data_out), .data_valid(data_valid), .idle(idle));
  asr_dev i_asr_dev (.core_clk(core_clk), .rst(rst), .link(link), .sample_in(sample_in),
    .conv_busy(conv_busy), .conv_done(conv_done));
  asr_chk i_asr_chk (.core_clk(core_clk), .rst(rst), .convert_strobe(link.convert_strobe),
    .select_chain_in(link.select_chain_in), .sck(link.sck),
    .serial_out_o(link.serial_out_o), .serial_out_oe(link.serial_out_oe));
  // ==========================================================================
  // Shared tasks.
  // ==========================================================================
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic results;
    if (n_fail == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // One transfer; the conversion length is counted apart from the strobe.
  task automatic xfer(input asr_mode_t m, input logic [17:0] v, input logic lead);
    int busy_n;
    int done_n;
    int k;
    busy_n = 0;
    done_n = 0;
    @(negedge core_clk);
    mode_in = m;
    sample_in = v;
    start = 1'b1;
    @(negedge core_clk);
    start = 1'b0;
    for (k = 0; k < 60 && conv_done !== 1'b1; k++) begin
      busy_n += (conv_busy === 1'b1);
      @(negedge core_clk);
    end
    busy_n += (conv_busy === 1'b1);
    done_n++;
    @(negedge core_clk);
    check(link.serial_out_oe, 1'b1);
    check(link.serial_out, lead);
    for (k = 0; k < 400 && data_valid !== 1'b1; k++) begin
      busy_n += (conv_busy === 1'b1);
      done_n += (conv_done === 1'b1);
      @(negedge core_clk);
    end
    check(data_valid, 1'b1);
    check(data_out, v);
    check(busy_n, ASR_TCONV_MAX_CYC);
    check(done_n, 1);
    @(negedge core_clk);
    check(idle, 1'b1);
  endtask
  // ==========================================================================
  // Scenarios.
  // ==========================================================================
  // Select mode with busy; the low lead bit proves the line is driven, not pulled.
  task automatic t_select;
    xfer(ASR_MODE_SEL, 18'h15555, 1'b0);
    xfer(ASR_MODE_SEL, 18'h3ffff, 1'b0);
  endtask
  // Chain without busy shows the MSB at once.
  task automatic t_chain;
    xfer(ASR_MODE_CHAIN, 18'h1fffe, 1'b0);
    xfer(ASR_MODE_CHAIN, 18'h20001, 1'b1);
  endtask
  // Chain with busy leads with a high bit whatever the MSB.
  task automatic t_chain_busy;
    xfer(ASR_MODE_CHAIN_BUSY, 18'h00000, 1'b1);
    xfer(ASR_MODE_CHAIN_BUSY, 18'h2aaaa, 1'b1);
  endtask
  // Mode changes back to back pick the mode from the pins each time.
  task automatic t_switch;
    xfer(ASR_MODE_CHAIN, 18'h00001, 1'b0);
    xfer(ASR_MODE_SEL, 18'h3fffe, 1'b0);
    xfer(ASR_MODE_CHAIN_BUSY, 18'h3ffff, 1'b1);
  endtask
  // ==========================================================================
  // Main sequence and watchdog.
  // ==========================================================================
  initial begin
    repeat (5) @(negedge core_clk);
    rst = 1'b0;
    t_select();
    t_chain();
    t_chain_busy();
    t_switch();
    results();
  end
  // A run needs about 1,600 cycles; this is far beyond it.
  initial begin
    #400000;
    n_fail++;
    results();
  end
endmodule // adc_serial_readout_chain_bench
`default_nettype wire
